// ==== hw/emc_mapper.sv ====
`timescale 1ns/1ps
// Function
// - a bit straight: e active when a=1
// - a bit inverted: e active when a=0
// - b bit straight: e active when b=1
// - b bit inverted: e active when b=0
// - non-m transmit bits take default nibble
// - forced idle holds e inactive during oos
// - forced busy holds e active during oos
// - two-phase patterns switch after 2.5 seconds
// - e1 voice channels use a-law
// - per-slot type; slot 0 sets all
// - masked e1 events kept out of log
// - management slot disabled at reset, ip only
module emc_mapper import emc_pkg::*; #(
  parameter int HOLD_CYC = EMC_OOS_HOLD_CYC
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire emc_bus_s bus,
  output logic [31:0] rdata,
  input wire logic [3:0] rx_signaling_nibble,
  input wire logic m_lead,
  input wire logic link_oos,
  input wire emc_evt_s evt,
  output logic e_lead,
  output logic [3:0] tx_signaling_nibble,
  output logic alaw_select,
  output logic mgmt_enable,
  output logic [4:0] mgmt_slot,
  output logic alarm_log_pulse,
  output logic [EMC_NEVT-1:0] alarm_log_evt,
  output logic irq
);

  initial
  begin
    if (HOLD_CYC < 2) $error("emc_mapper: HOLD_CYC too small");
  end

  // ****************************************************************
  // notes
  // ****************************************************************
  // the e lead and the transmit nibble are registered, so each change on
  // the link side shows one cycle later, the same on the level register.
  // the slot table only records types; steering voice or data through the
  // slots is done elsewhere, so a retype here moves no traffic by itself.
  // the phase timer counts core clocks, so HOLD_CYC must follow the real
  // clock rate; at 25 MHz it needs a 26-bit count, the 32-bit one is spare.

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    // configuration written by software
    logic [1:0] rxmode;
    logic [1:0] oos_mode;
    logic [3:0] def_nib;
    logic [1:0] mbit;
    logic [EMC_NSLOT-1:0][EMC_SLOTW-1:0] slot_type;
    logic mgmt_en;
    logic [4:0] mgmt_slot;
    // event masks and sticky records
    logic [EMC_NEVT-1:0] amask;
    logic [EMC_NEVT-1:0] alog;
    logic [2:0] istat;        // oos enter, oos leave, logged event
    logic [2:0] imask;
    logic [4:0] slot_sel;     // slot shown on read-back
    // lead state and registered outputs
    emc_state_e st;
    logic e_q;
    logic [3:0] tx_q;
    logic log_pulse;
    logic [EMC_NEVT-1:0] log_evt;
    logic [31:0] rdata;
  } emc_state_s;

  emc_state_s state_reg;
  emc_state_s state_next;
  logic phase_over;           // first out-of-service phase has run out
  logic mapped_e;             // e lead from received bits alone
  logic [EMC_NEVT-1:0] evt_vec;
  logic [EMC_NEVT-1:0] evt_kept;
  logic [EMC_NSLOT-1:0] slot_wr; // slots hit by the current slot write

  // select and optionally invert the received a or b bit
  function automatic logic map_rx(input logic [1:0] mode, input logic [3:0] nib);
    logic a_bit;
    logic b_bit;
    a_bit = nib[3];
    b_bit = nib[2];
    case (mode)
      EMC_RX_A: map_rx = a_bit;
      EMC_RX_A_INV: map_rx = ~a_bit;
      EMC_RX_B: map_rx = b_bit;
      default: map_rx = ~b_bit;
    endcase
  endfunction

  // slot number carried by a slot-table write
  function automatic logic [4:0] slot_field(input logic [31:0] w);
    slot_field = w[EMC_SLOT_NUM_LSB +: 5];
  endfunction

  // slot type carried by a slot-table write
  function automatic logic [EMC_SLOTW-1:0] type_field(input logic [31:0] w);
    type_field = w[EMC_SLOT_TYPE_LSB +: EMC_SLOTW];
  endfunction

  // ****************************************************************
  // helpers
  // ****************************************************************
  // the timer restarts whenever the link returns, so a short recovery
  // followed by a new outage always begins with a full first phase
  emc_oos_timer #(.HOLD_CYC(HOLD_CYC)) u_timer (
    .core_clk(core_clk),
    .reset(reset),
    .run(link_oos),
    .expired(phase_over)
  );

  assign mapped_e = map_rx(state_reg.rxmode, rx_signaling_nibble);
  assign evt_vec = evt;
  assign evt_kept = evt_vec & ~state_reg.amask;

  // ****************************************************************
  // slot table write decode
  // ****************************************************************
  // one select per slot; slot number 0 in the request hits every slot,
  // so a single write retypes the whole frame
  for (genvar g = 0; g < EMC_NSLOT; g++)
  begin : g_slot_wr
    assign slot_wr[g] = bus.wr && bus.addr == EMC_ADDR_SLOT &&
      (slot_field(bus.wdata) == EMC_SLOT_ALL || slot_field(bus.wdata) == 5'(g));
  end

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb
  begin
    state_next = state_reg;
    state_next.log_pulse = 1'b0;
    state_next.rdata = 32'h0;

    // out-of-service tracking
    // normal: link in service; first: timed first phase of an outage;
    // second: phase after the timer ran out, kept until the link returns.
    // the fixed patterns walk the same states but ignore the phase
    case (state_reg.st)
      EMC_ST_NORMAL:
      begin
        if (link_oos)
          state_next.st = EMC_ST_FIRST;
      end
      EMC_ST_FIRST:
      begin
        if (!link_oos)
          state_next.st = EMC_ST_NORMAL;
        else if (phase_over)
          state_next.st = EMC_ST_SECOND;
      end
      EMC_ST_SECOND:
      begin
        if (!link_oos)
          state_next.st = EMC_ST_NORMAL;
      end
      default: state_next.st = EMC_ST_NORMAL;
    endcase

    // e lead: forcing first, mapping otherwise
    // received bits are ignored for the whole outage, noise included
    if (link_oos)
    begin
      case (state_reg.oos_mode)
        EMC_OOS_IDLE: state_next.e_q = 1'b0;
        EMC_OOS_BUSY: state_next.e_q = 1'b1;
        EMC_OOS_IDLE_BUSY: state_next.e_q = (state_next.st == EMC_ST_SECOND);
        default: state_next.e_q = (state_next.st != EMC_ST_SECOND);
      endcase
    end
    else
      state_next.e_q = mapped_e;

    // transmit nibble: m lead on its bit, default elsewhere
    state_next.tx_q = state_reg.def_nib;
    // the m bit index names the nibble bit directly, 3 being the a bit
    state_next.tx_q[state_reg.mbit] = m_lead;

    // alarm log takes only unmasked events
    // a masked event leaves neither a pulse nor a log bit behind
    if (|evt_kept)
    begin
      state_next.log_pulse = 1'b1;
      state_next.log_evt = evt_kept;
      state_next.alog = state_reg.alog | evt_kept;
    end

    // register writes
    if (bus.wr)
    begin
      case (bus.addr)
        EMC_ADDR_CTRL:
        begin
          // a mode change takes effect on the next clock, with or without a new nibble
          state_next.rxmode = bus.wdata[EMC_CTRL_RXMODE_LSB +: 2];
          state_next.oos_mode = bus.wdata[EMC_CTRL_OOS_LSB +: 2];
          state_next.def_nib = bus.wdata[EMC_CTRL_DEFNIB_LSB +: 4];
          state_next.mbit = bus.wdata[EMC_CTRL_MBIT_LSB +: 2];
        end
        EMC_ADDR_SLOT:
        begin
          // every selected slot takes the new type at once
          for (int i = 0; i < EMC_NSLOT; i++)
          begin
            if (slot_wr[i])
              state_next.slot_type[i] = type_field(bus.wdata);
          end
          // the read-back port shows the slot named by the last write
          state_next.slot_sel = slot_field(bus.wdata);
        end
        EMC_ADDR_MGMT:
        begin
          // the management slot stays off until software sets the enable
          state_next.mgmt_en = bus.wdata[EMC_MGMT_EN_BIT];
          state_next.mgmt_slot = bus.wdata[EMC_MGMT_SLOT_LSB +: 5];
        end
        EMC_ADDR_AMASK: state_next.amask = bus.wdata[EMC_NEVT-1:0];
        EMC_ADDR_IMASK: state_next.imask = bus.wdata[EMC_NISTAT-1:0];
        default: ;                                 // unmapped writes ignored
      endcase
    end

    // register reads; reading status or log clears it
    // rdata drops back to zero after its one answer cycle, so a bus that
    // ors several slaves together needs no extra gating
    if (bus.rd)
    begin
      case (bus.addr)
        EMC_ADDR_CTRL: state_next.rdata = {21'h0, EMC_ALAW, state_reg.mbit,
          state_reg.def_nib, state_reg.oos_mode, state_reg.rxmode};
        EMC_ADDR_SLOTRD: state_next.rdata = {29'h0, state_reg.slot_type[state_reg.slot_sel]};
        EMC_ADDR_MGMT: state_next.rdata = {19'h0, state_reg.mgmt_slot, 7'h0, state_reg.mgmt_en};
        EMC_ADDR_AMASK: state_next.rdata = {21'h0, state_reg.amask};
        EMC_ADDR_STAT: state_next.rdata = {29'h0, state_reg.istat};
        EMC_ADDR_IMASK: state_next.rdata = {29'h0, state_reg.imask};
        // live view: phase, link state, e lead and the transmit nibble
        EMC_ADDR_LEVEL: state_next.rdata = {25'h0, state_reg.st == EMC_ST_SECOND,
          link_oos, state_reg.e_q, state_reg.tx_q};
        EMC_ADDR_ALOG: state_next.rdata = {21'h0, state_reg.alog};
        default: state_next.rdata = 32'h0;
      endcase
      if (bus.addr == EMC_ADDR_STAT)
        state_next.istat = 3'h0;
      if (bus.addr == EMC_ADDR_ALOG)
        state_next.alog = evt_kept;                // set wins over clear
    end

    // sticky events, set after any clear so the set wins
    // an event in the very cycle of the clearing read is never lost
    if (link_oos && state_reg.st == EMC_ST_NORMAL)
      state_next.istat[0] = 1'b1;
    if (!link_oos && state_reg.st != EMC_ST_NORMAL)
      state_next.istat[1] = 1'b1;
    if (|evt_kept)
      state_next.istat[2] = 1'b1;
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  // synchronous reset; the struct clears first, then def_nib, mbit, st and
  // mgmt_en are given their reset values, of which only mbit is not zero
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      state_reg <= '0;
      state_reg.def_nib <= EMC_DEFNIB_RESET;
      state_reg.mbit <= EMC_MBIT_RESET;
      state_reg.st <= EMC_ST_NORMAL;
      state_reg.mgmt_en <= 1'b0;
    end
    else
      state_reg <= state_next;
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  // lead and nibble come straight from flip-flops, free of glitches
  assign e_lead = state_reg.e_q;
  assign tx_signaling_nibble = state_reg.tx_q;
  // e1 voice is always a-law; no other companding path is built
  assign alaw_select = EMC_ALAW;
  // management slot only reported when enabled and typed for ip use
  assign mgmt_enable = state_reg.mgmt_en &&
    state_reg.slot_type[state_reg.mgmt_slot] == EMC_SLOT_MGMT;
  assign mgmt_slot = state_reg.mgmt_slot;
  assign alarm_log_pulse = state_reg.log_pulse;
  assign alarm_log_evt = state_reg.log_evt;
  // level interrupt, high while an unmasked sticky bit is set
  assign irq = |(state_reg.istat & state_reg.imask);
  assign rdata = state_reg.rdata;

endmodule // emc_mapper

// ==== hw/emc_oos_timer.sv ====
`timescale 1ns/1ps
// ****************************************************************
// phase timer for the two-phase out-of-service patterns
// ****************************************************************
module emc_oos_timer import emc_pkg::*; #(
  parameter int HOLD_CYC = EMC_OOS_HOLD_CYC
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic run,
  output logic expired
);

  initial
  begin
    if (HOLD_CYC < 2) $error("emc_oos_timer: HOLD_CYC too small");
  end

  // timer state held as one struct
  typedef struct packed {
    logic [31:0] cnt;
    logic done;
  } emc_tmr_s;

  emc_tmr_s state_reg;
  emc_tmr_s state_next;

  // count while run is high; restart the moment run drops
  always_comb
  begin
    state_next = state_reg;
    if (!run)
    begin
      state_next.cnt = 32'h0;
      state_next.done = 1'b0;
    end
    else if (!state_reg.done)
    begin
      if (state_reg.cnt == 32'(HOLD_CYC - 1))
        state_next.done = 1'b1;
      else
        state_next.cnt = state_reg.cnt + 32'h1;
    end
  end

  // register the struct
  always_ff @(posedge core_clk)
  begin
    if (reset)
      state_reg <= '0;
    else
      state_reg <= state_next;
  end

  assign expired = state_reg.done;

endmodule // emc_oos_timer

// ==== hw/emc_pkg.sv ====
package emc_pkg;

  // ****************************************************************
  // register map (word index on the plain register port)
  // ****************************************************************
  localparam logic [3:0] EMC_ADDR_CTRL = 4'h0;      // modes, default nibble
  localparam logic [3:0] EMC_ADDR_SLOT = 4'h1;      // slot type write port
  localparam logic [3:0] EMC_ADDR_MGMT = 4'h2;      // management slot control
  localparam logic [3:0] EMC_ADDR_AMASK = 4'h3;     // alarm event mask
  localparam logic [3:0] EMC_ADDR_STAT = 4'h4;      // sticky event status
  localparam logic [3:0] EMC_ADDR_IMASK = 4'h5;     // interrupt mask
  localparam logic [3:0] EMC_ADDR_LEVEL = 4'h6;     // live lead state
  localparam logic [3:0] EMC_ADDR_ALOG = 4'h7;      // alarm log (sticky)
  localparam logic [3:0] EMC_ADDR_SLOTRD = 4'h8;    // slot type read-back

  // ****************************************************************
  // control field layout
  // ****************************************************************
  localparam int EMC_CTRL_RXMODE_LSB = 0;           // 2 bits receive mode
  localparam int EMC_CTRL_OOS_LSB = 2;              // 2 bits out-of-service method
  localparam int EMC_CTRL_DEFNIB_LSB = 4;           // 4 bits default nibble
  localparam int EMC_CTRL_MBIT_LSB = 8;             // index of m-lead bit
  localparam int EMC_CTRL_LAW_BIT = 10;             // read-only a-law flag
  localparam int EMC_MGMT_EN_BIT = 0;               // management slot enable
  localparam int EMC_MGMT_SLOT_LSB = 8;             // management slot number
  localparam int EMC_NISTAT = 3;                    // sticky status bits
  localparam logic [3:0] EMC_DEFNIB_RESET = 4'h0;
  localparam logic [1:0] EMC_MBIT_RESET = 2'h3;     // m lead on bit a
  localparam logic EMC_ALAW = 1'b1;                 // e1 voice always a-law

  // ****************************************************************
  // slot table
  // ****************************************************************
  localparam int EMC_NSLOT = 32;
  localparam int EMC_SLOTW = 3;
  localparam logic [2:0] EMC_SLOT_UNASSIGNED = 3'h0;
  localparam logic [2:0] EMC_SLOT_MGMT = 3'h7;      // management_slot_type
  localparam logic [4:0] EMC_SLOT_ALL = 5'h00;      // slot 0 means all slots
  localparam int EMC_SLOT_NUM_LSB = 0;              // slot write: slot number
  localparam int EMC_SLOT_TYPE_LSB = 8;             // slot write: slot type

  // ****************************************************************
  // events and timing
  // ****************************************************************
  localparam int EMC_NEVT = 11;
  localparam int EMC_CLK_HZ = 25000000;
  localparam int EMC_OOS_HOLD_MS = 2500;            // 2.5 s first phase
  localparam int EMC_OOS_HOLD_CYC = EMC_CLK_HZ / 1000 * EMC_OOS_HOLD_MS;

  typedef enum logic [1:0] {EMC_RX_A, EMC_RX_A_INV, EMC_RX_B, EMC_RX_B_INV} emc_rxmode_e;
  typedef enum logic [1:0] {EMC_OOS_IDLE, EMC_OOS_BUSY, EMC_OOS_IDLE_BUSY,
    EMC_OOS_BUSY_IDLE} emc_oos_e;
  typedef enum {EMC_ST_NORMAL, EMC_ST_FIRST, EMC_ST_SECOND} emc_state_e;

  // register port request
  typedef struct packed {
    logic [3:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } emc_bus_s;

  // e1 event inputs, one pulse per event class
  typedef struct packed {
    logic ais;
    logic remote_mf;
    logic local_mf;
    logic local_sync;
    logic remote_sync;
    logic signal_loss;
    logic excess_err;
    logic crc4;
    logic excess_bpv;
    logic bpv;
    logic slip;
  } emc_evt_s;

endpackage

// ==== verif/emc_e1_model.sv ====
`timescale 1ns/1ps
// ****************************************************************
// far-end e1 framer: received signaling, link state, event pulses
// ****************************************************************
module emc_e1_model import emc_pkg::*; (
  input wire logic core_clk,
  input wire logic [3:0] tx_signaling_nibble,
  output logic [3:0] rx_signaling_nibble,
  output logic link_oos,
  output emc_evt_s evt,
  output logic [3:0] tx_seen
);
  // quiet line from time zero so the mapper never sees unknowns
  initial
  begin
    rx_signaling_nibble = 4'h0;
    link_oos = 1'b0;
    evt = '0;
  end
  // the framer picks up the transmitted nibble one clock later
  always @(posedge core_clk)
    tx_seen <= tx_signaling_nibble;
  task automatic set_nib(input logic [3:0] n);
    @(posedge core_clk);
    rx_signaling_nibble <= n;
  endtask
  task automatic set_oos(input logic b);
    @(posedge core_clk);
    link_oos <= b;
  endtask
  // events are single-cycle pulses, never stretched
  task automatic pulse(input emc_evt_s e);
    @(posedge core_clk);
    evt <= e;
    @(posedge core_clk);
    evt <= '0;
  endtask
endmodule // emc_e1_model

// ==== verif/emc_mapper_properties.sv ====
`timescale 1ns/1ps
// ****************************************************************
// port checker for the e&m signaling mapper
// ****************************************************************
module emc_mapper_properties import emc_pkg::*; #(
  parameter int HOLD_CYC = EMC_OOS_HOLD_CYC
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire emc_bus_s bus,
  input wire logic m_lead,
  input wire logic [3:0] rx_signaling_nibble,
  input wire logic link_oos,
  input wire emc_evt_s evt,
  input wire logic e_lead,
  input wire logic [3:0] tx_signaling_nibble,
  input wire logic alaw_select,
  input wire logic mgmt_enable,
  input wire logic alarm_log_pulse,
  input wire logic [EMC_NEVT-1:0] alarm_log_evt,
  input wire logic irq
);
  logic [7:0] ctrl_reg; // shadow of mode, method and default nibble
  logic [10:0] amask_reg; // shadow of the alarm mask
  int cnt_reg; // consecutive cycles out of service
  logic [10:0] hit; // events that must reach the log
  logic sel; // received bit chosen by the mode
  assign hit = evt & ~amask_reg;
  assign sel = ctrl_reg[1] ? rx_signaling_nibble[2] : rx_signaling_nibble[3];
  // shadows track writes so the checks know the setup without peeking inside
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      ctrl_reg <= 8'h00;
      amask_reg <= 11'h000;
      cnt_reg <= 0;
    end
    else
    begin
      if (bus.wr && bus.addr == EMC_ADDR_CTRL)
        ctrl_reg <= bus.wdata[7:0];
      if (bus.wr && bus.addr == EMC_ADDR_AMASK)
        amask_reg <= bus.wdata[10:0];
      cnt_reg <= link_oos ? cnt_reg + 1 : 0;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  map_ok_a: assert property (
    !$past(reset) && !$past(link_oos) |-> e_lead == $past(sel ^ ctrl_reg[0]))
    else $error("e lead does not follow the selected bit");
  fixed_oos_a: assert property (
    !$past(reset) && $past(link_oos && !ctrl_reg[3]) |-> e_lead == $past(ctrl_reg[2]))
    else $error("fixed out-of-service level wrong");
  oos_phase_a: assert property (
    !$past(reset) && $past(link_oos && ctrl_reg[3])
    |-> e_lead == (($past(cnt_reg) >= HOLD_CYC) ^ $past(ctrl_reg[2])))
    else $error("two-phase out-of-service level wrong");
  tx_default_a: assert property (
    !$past(reset) |-> $countones(tx_signaling_nibble ^ $past(ctrl_reg[7:4])) <= 1)
    else $error("transmit nibble strays from default");
  alaw_on_a: assert property (alaw_select)
    else $error("a-law select dropped");
  log_event_a: assert property (
    !$past(reset) && $past(|hit) |-> alarm_log_pulse && alarm_log_evt == $past(hit))
    else $error("unmasked event not logged");
  log_quiet_a: assert property (
    !$past(reset) && !$past(|hit) |-> !alarm_log_pulse)
    else $error("log pulse without unmasked event");
  mgmt_off_a: assert property ($past(reset) |-> !mgmt_enable)
    else $error("management slot live after reset");
  cover property ($past(link_oos && ctrl_reg[3]) && $past(cnt_reg) == HOLD_CYC);
  cover property (alarm_log_pulse);
  cover property (irq);
endmodule // emc_mapper_properties

bind emc_mapper emc_mapper_properties #(.HOLD_CYC(HOLD_CYC)) i_props (.core_clk, .reset,
  .bus, .m_lead, .rx_signaling_nibble, .link_oos, .evt, .e_lead, .tx_signaling_nibble,
  .alaw_select, .mgmt_enable, .alarm_log_pulse, .alarm_log_evt, .irq);

// ==== verif/testbench.sv ====
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin checks++; if ((got) !== (exp)) begin error_cnt++; \
  $display("unexpected %s: expected %0h seen %0h", nm, exp, got); end end
// ****************************************************************
// self-checking bench for the e&m mapper
// ****************************************************************
module testbench import emc_pkg::*;;
  localparam int HOLD = 20; // short stand-in for the 2.5 s phase
  logic core_clk, reset, m_lead, link_oos, e_lead, alaw, mgmt_en, log_pulse, irq;
  emc_bus_s bus;
  emc_evt_s evt;
  logic [31:0] rdata;
  logic [3:0] rx_nib, tx_nib, tx_seen;
  logic [4:0] mgmt_slot;
  logic [10:0] log_evt;
  int error_cnt, checks;
  emc_mapper #(.HOLD_CYC(HOLD)) i_dut (.core_clk, .reset, .bus, .rdata,
    .rx_signaling_nibble(rx_nib), .m_lead, .link_oos, .evt, .e_lead,
    .tx_signaling_nibble(tx_nib), .alaw_select(alaw), .mgmt_enable(mgmt_en), .mgmt_slot,
    .alarm_log_pulse(log_pulse), .alarm_log_evt(log_evt), .irq);
  emc_e1_model i_e1 (.core_clk, .tx_signaling_nibble(tx_nib),
    .rx_signaling_nibble(rx_nib), .link_oos, .evt, .tx_seen);
  initial
  begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  // one-cycle strobes launched after an edge; a gap edge keeps drivers clean
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk);
    bus.wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge core_clk);
    bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk);
    bus.rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic t_reg();
    logic [31:0] d;
    rd(EMC_ADDR_CTRL, d);
    `CHK("ctrl reset", 32'h0000_0700, d)
    `CHK("alaw", 1'b1, alaw)
    `CHK("mgmt reset", 1'b0, mgmt_en)
    wr(4'hF, 32'hFFFF_FFFF);
    rd(4'hF, d);
    `CHK("unmapped", 32'h0, d)
    wr(EMC_ADDR_SLOT, 32'h0000_0700); // slot 0 sets every slot
    wr(EMC_ADDR_MGMT, 32'h0000_0501);
    tick(1);
    `CHK("mgmt on", 1'b1, mgmt_en)
    `CHK("mgmt slot", 5'h05, mgmt_slot)
    wr(EMC_ADDR_SLOT, 32'h0000_0005);
    rd(EMC_ADDR_SLOTRD, d);
    `CHK("slot type", 32'h0, d)
    `CHK("mgmt gone", 1'b0, mgmt_en)
    $display("test registers done");
  endtask
  task automatic t_map();
    for (int m = 0; m < 4; m++)
    begin
      wr(EMC_ADDR_CTRL, 32'h300 | m);
      for (int k = 0; k < 4; k++)
      begin
        i_e1.set_nib(4'(k << 2));
        tick(2);
        `CHK("e lead", (m[1] ? k[0] : k[1]) ^ m[0], e_lead)
      end
    end
    $display("test mapping done");
  endtask
  // every m bit position, with the default nibble opposite to the m level
  task automatic t_tx();
    for (int i = 0; i < 8; i++)
    begin
      wr(EMC_ADDR_CTRL, (i[2] ? 32'h0 : 32'hF0) | ((i % 4) << 8));
      @(posedge core_clk);
      m_lead <= i[2];
      tick(3);
      `CHK("tx nibble", 4'(i[2] ? (1 << (i % 4)) : ~(1 << (i % 4))), tx_seen)
    end
    $display("test transmit done");
  endtask
  // mapping is set to the opposite of each first-phase forced level
  task automatic t_oos();
    logic [31:0] d;
    for (int m = 0; m < 4; m++)
    begin
      wr(EMC_ADDR_CTRL, 32'h300 | (m << 2));
      i_e1.set_nib(m[0] ? 4'h0 : 4'h8);
      i_e1.set_oos(1'b1);
      tick(3);
      `CHK("oos first", m[0], e_lead)
      tick(HOLD);
      `CHK("oos second", m[0] ^ m[1], e_lead)
      rd(EMC_ADDR_LEVEL, d);
      `CHK("level", 3'h6 | 3'(m[0] ^ m[1]), d[6:4])
      i_e1.set_oos(1'b0);
      tick(1);
      `CHK("oos resume", !m[0], e_lead)
    end
    $display("test out of service done");
  endtask
  task automatic t_log();
    logic [31:0] d;
    rd(EMC_ADDR_STAT, d);
    `CHK("status oos", 32'h3, d)
    rd(EMC_ADDR_ALOG, d);
    `CHK("log empty", 32'h0, d)
    wr(EMC_ADDR_IMASK, 32'h0);
    for (int i = 0; i < EMC_NEVT; i++)
    begin
      i_e1.pulse(emc_evt_s'(11'h1 << i));
      #1;
      `CHK("log pulse", 1'b1, log_pulse)
      `CHK("log event", 11'h1 << i, log_evt)
    end
    tick(1);
    `CHK("irq masked", 1'b0, irq)
    wr(EMC_ADDR_IMASK, 32'h4);
    tick(1);
    `CHK("irq raised", 1'b1, irq)
    rd(EMC_ADDR_ALOG, d);
    `CHK("alarm log", 32'h7FF, d)
    rd(EMC_ADDR_STAT, d);
    `CHK("status", 32'h4, d)
    tick(1);
    `CHK("irq cleared", 1'b0, irq)
    wr(EMC_ADDR_AMASK, 32'h7FF);
    i_e1.pulse(emc_evt_s'(11'h7FF));
    #1;
    `CHK("masked pulse", 1'b0, log_pulse)
    rd(EMC_ADDR_ALOG, d);
    `CHK("masked log", 32'h0, d)
    $display("test alarm log done");
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // all tests need well under 2000 cycles
  initial
  begin
    #200000;
    error_cnt++;
    conclude();
  end
  initial
  begin
    bus = '0;
    m_lead = 1'b0;
    reset = 1'b1;
    repeat (6) @(posedge core_clk);
    reset <= 1'b0;
    t_reg();
    t_map();
    t_tx();
    t_oos();
    t_log();
    conclude();
  end
endmodule // testbench
